// *** pkg/ptc_consts.vh ***
// Purpose: constants of the periodic timer control block
// Assumes: byte-wide register port, one clock at 125 MHz
// Notes: offsets are register indices on the plain register port
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH
`define PTC_ADDR_W 3
`define PTC_OFF_CTRL0 3'h0
`define PTC_OFF_CTRL1 3'h1
`define PTC_OFF_CNT_LO 3'h2
`define PTC_OFF_CNT_HI 3'h3
`define PTC_OFF_CMPA_LO 3'h4
`define PTC_OFF_CMPA_HI 3'h5
`define PTC_OFF_PER_LO 3'h6
`define PTC_OFF_PER_HI 3'h7
`define PTC_CTRL0_RST 8'h00
`define PTC_CTRL1_RST 8'h00
`define PTC_CTRL0_WMASK 8'hF8
`define PTC_POS_PAUSE 7
`define PTC_POS_CLK_HI 6
`define PTC_POS_CLK_LO 4
`define PTC_POS_ON 3
`define PTC_POS_MODE_HI 7
`define PTC_POS_MODE_LO 6
`define PTC_POS_PIN_HI 5
`define PTC_POS_PIN_LO 4
`define PTC_POS_OLC 3
`define PTC_POS_POL 2
`define PTC_POS_CAPS 1
`define PTC_POS_CLR 0
`define PTC_MODE_CMP 2'h0
`define PTC_MODE_CAP 2'h1
`define PTC_MODE_PWM 2'h2
`define PTC_MODE_TMR 2'h3
`define PTC_CLK_SYS4 3'h0
`define PTC_CLK_SYS 3'h1
`define PTC_CLK_H16 3'h2
`define PTC_CLK_H64 3'h3
`define PTC_CLK_SUB0 3'h4
`define PTC_CLK_SUB1 3'h5
`define PTC_CLK_EXTR 3'h6
`define PTC_CLK_EXTF 3'h7
`define PTC_DIV4 8'h03
`define PTC_DIV16 8'h0F
`define PTC_DIV64 8'h3F
`define PTC_CNT_MAX 10'h3FF
`endif

// *** rtl/ptc_timer.v ***
// Purpose: 10-bit periodic timer with compare, capture, PWM and single pulse
// Assumes: high and sub clocks arrive as one-cycle enables on clock_i
// Notes: external pins pass two flip-flops before use
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.vh"

// Operation
// - clock source field picks counter clock
// - on-bit rise zeroes counter, starts count
// - on-bit clear stops, holds residual value
// - on-bit rise restores output initial level
// - control 0 bits 2..0 read zero
// - mode field bits 7..6 selects mode
// - timer mode: output unused, pin field unused
// - compare A match: none/low/high/toggle output
// - pwm mode: inactive/active/pwm/single pulse
// - capture edge: rise/fall/both/disabled
// - requested level equal initial: no change
// - output control sets initial level
// - pwm output control sets active level
// - polarity inverts output, not timer mode
// - capture source: capture pin or clock pin
// - clear on A match or P/overflow
// - overflow clearing only when period zero or single pulse
// - clear bit ignored pwm, pulse, capture
// - counter readable as low/high pair
// - compare A and period pairs, reset zero
// - pause freezes counter, resumes from value
// - comparators use all ten counter bits
module ptc_timer (
    input wire clock_i,
    input wire rst_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire high_clock_en_i,
    input wire sub_clock_en_i,
    input wire external_clock_pin_i,
    input wire capture_input_pin_i,
    output reg timer_output_pin_o,
    output wire timer_output_pin_n_o,
    output reg compare_a_event_o,
    output reg compare_p_event_o,
    output reg capture_event_o
);

////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ctrl0_q;
reg [7:0] ctrl1_q;
reg [9:0] cmpa_q;
reg [9:0] per_q;
reg [9:0] cnt_q;
reg on_prev_q;
reg out_q;
reg [7:0] div_q;
reg [7:0] hdiv_q;
reg [1:0] ck_sync_q;
reg [1:0] pi_sync_q;
reg ck_prev_q;
reg pi_prev_q;

wire counter_pause = ctrl0_q[`PTC_POS_PAUSE];
wire [2:0] clock_source_select = ctrl0_q[`PTC_POS_CLK_HI:`PTC_POS_CLK_LO];
wire counter_on = ctrl0_q[`PTC_POS_ON];
wire [1:0] operating_mode_select = ctrl1_q[`PTC_POS_MODE_HI:`PTC_POS_MODE_LO];
wire [1:0] pin_function_select = ctrl1_q[`PTC_POS_PIN_HI:`PTC_POS_PIN_LO];
wire output_level_control = ctrl1_q[`PTC_POS_OLC];
wire output_polarity = ctrl1_q[`PTC_POS_POL];
wire capture_source_select = ctrl1_q[`PTC_POS_CAPS];
wire clear_condition_select = ctrl1_q[`PTC_POS_CLR];

wire mode_cmp = (operating_mode_select == `PTC_MODE_CMP);
wire mode_cap = (operating_mode_select == `PTC_MODE_CAP);
wire mode_pwm = (operating_mode_select == `PTC_MODE_PWM);
wire mode_tmr = (operating_mode_select == `PTC_MODE_TMR);
wire single_pulse = mode_pwm && (pin_function_select == 2'h3);

////////////////////////////////////////////////////////////////////////
// pin synchronisers and edges
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ck_sync_q <= 2'h0;
        pi_sync_q <= 2'h0;
        ck_prev_q <= 1'b0;
        pi_prev_q <= 1'b0;
    end else begin
        ck_sync_q <= {ck_sync_q[0], external_clock_pin_i};
        pi_sync_q <= {pi_sync_q[0], capture_input_pin_i};
        ck_prev_q <= ck_sync_q[1];
        pi_prev_q <= pi_sync_q[1];
    end
end

wire ck_rise = ck_sync_q[1] && !ck_prev_q;
wire ck_fall = !ck_sync_q[1] && ck_prev_q;
wire pi_rise = pi_sync_q[1] && !pi_prev_q;
wire pi_fall = !pi_sync_q[1] && pi_prev_q;

////////////////////////////////////////////////////////////////////////
// clock source selection
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        div_q <= 8'h00;
        hdiv_q <= 8'h00;
    end else begin
        div_q <= div_q + 8'h01;
        if (high_clock_en_i) begin
            hdiv_q <= hdiv_q + 8'h01;
        end
    end
end

reg tick;
always @* begin
    case (clock_source_select)
        `PTC_CLK_SYS4: tick = ((div_q & `PTC_DIV4) == `PTC_DIV4);
        `PTC_CLK_SYS: tick = 1'b1;
        `PTC_CLK_H16: tick = high_clock_en_i && ((hdiv_q & `PTC_DIV16) == `PTC_DIV16);
        `PTC_CLK_H64: tick = high_clock_en_i && ((hdiv_q & `PTC_DIV64) == `PTC_DIV64);
        `PTC_CLK_SUB0: tick = sub_clock_en_i;
        `PTC_CLK_SUB1: tick = sub_clock_en_i;
        `PTC_CLK_EXTR: tick = ck_rise;
        `PTC_CLK_EXTF: tick = ck_fall;
        default: tick = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////
// comparators and clear logic
wire on_rise = counter_on && !on_prev_q;
wire run = counter_on && !counter_pause && !on_rise;
wire step = run && tick;
wire [9:0] cnt_next = cnt_q + 10'h001;
wire match_a = step && (cnt_next == cmpa_q) && (cmpa_q != 10'h000);
wire match_p = step && (cnt_next == per_q) && (per_q != 10'h000);
wire overflow = step && (cnt_q == `PTC_CNT_MAX);
// clear select only counts in compare and timer modes
wire use_clr = (mode_cmp || mode_tmr) && clear_condition_select;
// single pulse leaves the period compare unused
wire clr_cnt = use_clr ? match_a : (match_p && !single_pulse);
wire pulse_end = single_pulse && match_a;

// capture trigger
wire trg_rise = capture_source_select ? ck_rise : pi_rise;
wire trg_fall = capture_source_select ? ck_fall : pi_fall;
reg cap_hit;
always @* begin
    case (pin_function_select)
        2'h0: cap_hit = trg_rise;
        2'h1: cap_hit = trg_fall;
        2'h2: cap_hit = trg_rise || trg_fall;
        default: cap_hit = 1'b0;
    endcase
end
wire capture = mode_cap && counter_on && cap_hit;

// single pulse may be started by a clock pin rising edge
wire sp_start = single_pulse && !counter_on && ck_rise;

////////////////////////////////////////////////////////////////////////
// register writes and hardware updates
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ctrl0_q <= `PTC_CTRL0_RST;
        ctrl1_q <= `PTC_CTRL1_RST;
        cmpa_q <= 10'h000;
        per_q <= 10'h000;
        on_prev_q <= 1'b0;
    end else begin
        on_prev_q <= counter_on;
        if (wr_i) begin
            case (addr_i)
                `PTC_OFF_CTRL0: ctrl0_q <= wdata_i & `PTC_CTRL0_WMASK;
                `PTC_OFF_CTRL1: ctrl1_q <= wdata_i;
                `PTC_OFF_CMPA_LO: cmpa_q[7:0] <= wdata_i;
                `PTC_OFF_CMPA_HI: cmpa_q[9:8] <= wdata_i[1:0];
                `PTC_OFF_PER_LO: per_q[7:0] <= wdata_i;
                `PTC_OFF_PER_HI: per_q[9:8] <= wdata_i[1:0];
                default: ;
            endcase
        end
        // hardware wins over a same-cycle write
        if (pulse_end) begin
            ctrl0_q[`PTC_POS_ON] <= 1'b0;
        end else if (sp_start) begin
            ctrl0_q[`PTC_POS_ON] <= 1'b1;
        end
        if (capture) begin
            cmpa_q <= cnt_q;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// counter
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        cnt_q <= 10'h000;
    end else if (on_rise) begin
        cnt_q <= 10'h000;
    end else if (step) begin
        if (clr_cnt || overflow) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// output stage
reg out_d;
always @* begin
    out_d = out_q;
    if (on_rise) begin
        out_d = output_level_control;
    end else if (mode_cmp && match_a) begin
        case (pin_function_select)
            2'h1: out_d = 1'b0;
            2'h2: out_d = 1'b1;
            2'h3: out_d = !out_q;
            default: out_d = out_q;
        endcase
    end else if (pulse_end || (single_pulse && !counter_on)) begin
        out_d = !output_level_control;
    end
end

// pwm duty: active while count below compare A
wire pwm_active = counter_on && (cnt_q < cmpa_q);
reg pin_raw;
always @* begin
    if (mode_pwm) begin
        case (pin_function_select)
            2'h0: pin_raw = !output_level_control;
            2'h1: pin_raw = output_level_control;
            2'h2: pin_raw = pwm_active ? output_level_control : !output_level_control;
            default: pin_raw = out_q;
        endcase
    end else if (mode_tmr) begin
        pin_raw = 1'b0;
    end else begin
        pin_raw = out_q;
    end
end

always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        out_q <= 1'b0;
        timer_output_pin_o <= 1'b0;
        compare_a_event_o <= 1'b0;
        compare_p_event_o <= 1'b0;
        capture_event_o <= 1'b0;
    end else begin
        out_q <= out_d;
        timer_output_pin_o <= pin_raw ^ (output_polarity && !mode_tmr);
        compare_a_event_o <= match_a && !mode_cap;
        compare_p_event_o <= match_p && !use_clr && !single_pulse;
        capture_event_o <= capture;
    end
end

assign timer_output_pin_n_o = !timer_output_pin_o;

////////////////////////////////////////////////////////////////////////
// read port
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        case (addr_i)
            `PTC_OFF_CTRL0: rdata_o <= ctrl0_q & `PTC_CTRL0_WMASK;
            `PTC_OFF_CTRL1: rdata_o <= ctrl1_q;
            `PTC_OFF_CNT_LO: rdata_o <= cnt_q[7:0];
            `PTC_OFF_CNT_HI: rdata_o <= {6'h00, cnt_q[9:8]};
            `PTC_OFF_CMPA_LO: rdata_o <= cmpa_q[7:0];
            `PTC_OFF_CMPA_HI: rdata_o <= {6'h00, cmpa_q[9:8]};
            `PTC_OFF_PER_LO: rdata_o <= per_q[7:0];
            `PTC_OFF_PER_HI: rdata_o <= {6'h00, per_q[9:8]};
            default: rdata_o <= 8'h00;
        endcase
    end else begin
        rdata_o <= 8'h00;
    end
end

endmodule // ptc_timer
`default_nettype wire

// *** sim/ptc_timer_monitor.sv ***
// Purpose: port checker for the periodic timer
// Assumes: control 1 and period are shadowed from port writes
// Notes: bound to every ptc_timer instance
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.vh"
module ptc_timer_monitor (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic high_clock_en_i,
    input wire logic sub_clock_en_i,
    input wire logic external_clock_pin_i,
    input wire logic capture_input_pin_i,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_n_o,
    input wire logic compare_a_event_o,
    input wire logic compare_p_event_o,
    input wire logic capture_event_o
);
    logic [7:0] ctl1_q;
    logic [9:0] per_q;
    logic cap_m;
    assign cap_m = ctl1_q[7:6] == `PTC_MODE_CAP;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl1_q <= 8'h00;
            per_q <= 10'h000;
        end else if (wr_i) begin
            if (addr_i == `PTC_OFF_CTRL1) ctl1_q <= wdata_i;
            if (addr_i == `PTC_OFF_PER_LO) per_q[7:0] <= wdata_i;
            if (addr_i == `PTC_OFF_PER_HI) per_q[9:8] <= wdata_i[1:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_ctl0;
        rd_i && addr_i == `PTC_OFF_CTRL0;
    endsequence
    sequence s_rd_hi;
        rd_i && (addr_i == `PTC_OFF_CNT_HI || addr_i == `PTC_OFF_CMPA_HI || addr_i == `PTC_OFF_PER_HI);
    endsequence
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    chk_ctl0_low: assert property (s_rd_ctl0 |=> rdata_o[2:0] == 3'h0)
        else $error("ctrl0 low bits set");
    chk_high_bytes: assert property (s_rd_hi |=> rdata_o[7:2] == 6'h00)
        else $error("high byte upper bits");
    chk_ctl1_read: assert property (rd_i && addr_i == `PTC_OFF_CTRL1 |=> rdata_o == $past(ctl1_q))
        else $error("ctrl1 readback wrong");
    chk_pin_compl: assert property (timer_output_pin_n_o == !timer_output_pin_o)
        else $error("pin pair not inverse");
    chk_cap_no_a: assert property (cap_m && $past(cap_m) |-> !compare_a_event_o)
        else $error("A event in capture");
    chk_cap_only: assert property (!cap_m && !$past(cap_m) |-> !capture_event_o)
        else $error("capture outside mode");
    chk_no_p_zero: assert property (per_q == 10'h000 && $past(per_q) == 10'h000 |-> !compare_p_event_o)
        else $error("P event with zero period");
    chk_no_p_clr: assert property ($stable(ctl1_q) && ctl1_q[7:6] == `PTC_MODE_CMP && ctl1_q[0] |-> !compare_p_event_o)
        else $error("P event with A clearing");
endmodule // ptc_timer_monitor
bind ptc_timer ptc_timer_monitor i_ptc_timer_monitor (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .high_clock_en_i(high_clock_en_i),
    .sub_clock_en_i(sub_clock_en_i), .external_clock_pin_i(external_clock_pin_i),
    .capture_input_pin_i(capture_input_pin_i), .timer_output_pin_o(timer_output_pin_o),
    .timer_output_pin_n_o(timer_output_pin_n_o), .compare_a_event_o(compare_a_event_o),
    .compare_p_event_o(compare_p_event_o), .capture_event_o(capture_event_o));
`default_nettype wire

// *** sim/ptc_pin_model.sv ***
// Purpose: external pins and slow clock enables of the timer
// Assumes: enables are one-cycle pulses on the system clock
// Notes: pin edges spaced four cycles, above the sync limit
`timescale 1ns/10ps
`default_nettype none
module ptc_pin_model (
    input wire logic clock_i,
    output logic high_clock_en_o,
    output logic sub_clock_en_o,
    output logic ext_pin_o,
    output logic cap_pin_o
);
    logic [2:0] div_q;
    initial begin
        div_q = 3'h0;
        high_clock_en_o = 1'b0;
        sub_clock_en_o = 1'b0;
        ext_pin_o = 1'b0;
        cap_pin_o = 1'b0;
    end
    // high clock every 2 cycles, sub clock every 8
    always @(posedge clock_i) begin
        div_q <= div_q + 3'h1;
        high_clock_en_o <= div_q[0];
        sub_clock_en_o <= div_q == 3'h7;
    end
    task automatic pulse(input logic sel, input int n);
        repeat (n) begin
            repeat (4) @(posedge clock_i);
            if (sel) ext_pin_o <= ~ext_pin_o;
            else cap_pin_o <= ~cap_pin_o;
        end
    endtask
endmodule // ptc_pin_model
`default_nettype wire

// *** sim/tb_periodic_timer_control.sv ***
// Purpose: self-checking bench of the periodic timer
// Assumes: pin model supplies slow enables and pin edges
// Notes: timer switched off before every mode change
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.vh"
`define TB_CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_periodic_timer_control;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] v;
    wire [7:0] rdata_o;
    wire tpin, tpin_n, ev_a, ev_p, ev_cap, hen, sen, ext, cap;
    int errors = 0, n_compared = 0, cyc = 0, n_cap = 0, n_a = 0, n_p = 0, i, hi, n0;
    int nw[6] = '{40, 10, 320, 640, 80, 80};
    int ex[6] = '{10, 10, 10, 5, 10, 10};
    int cx[5] = '{1, 1, 2, 0, 1};
    int px[3] = '{0, 100, 50};
    ptc_timer i_ptc_timer (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .high_clock_en_i(hen), .sub_clock_en_i(sen), .external_clock_pin_i(ext),
        .capture_input_pin_i(cap), .timer_output_pin_o(tpin), .timer_output_pin_n_o(tpin_n),
        .compare_a_event_o(ev_a), .compare_p_event_o(ev_p), .capture_event_o(ev_cap));
    ptc_pin_model i_ptc_pin_model (.clock_i(clock_i), .high_clock_en_o(hen), .sub_clock_en_o(sen),
        .ext_pin_o(ext), .cap_pin_o(cap));
    always #4 clock_i = ~clock_i;
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (ev_cap === 1'b1) n_cap <= n_cap + 1;
        if (ev_a === 1'b1) n_a <= n_a + 1;
        if (ev_p === 1'b1) n_p <= n_p + 1;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
        rd(a, v);
        `TB_CHK(nm, e, v)
    endtask
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h0, c0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i++) rdc("reset", i[2:0], 8'h00);
        wr(3'h0, 8'hFF);
        rdc("ctl0", 3'h0, 8'hF8);
        wr(3'h2, 8'h55);
        rdc("cnt ro", 3'h2, 8'h00);
        wr(3'h5, 8'hFF);
        rdc("cmpa hi", 3'h5, 8'h03);
        wr(3'h7, 8'hFF);
        rdc("per hi", 3'h7, 8'h03);
        wr(3'h7, 8'h00);
        wr(3'h0, 8'h18);
        wr(3'h0, 8'h98);
        rd(3'h2, v);
        rdc("pause", 3'h2, v);
        wr(3'h0, 8'h10);
        rd(3'h2, v);
        rdc("off hold", 3'h2, v);
        wr(3'h0, 8'h98);
        rdc("on clear", 3'h2, 8'h00);
        for (i = 0; i < 8; i++) begin
            start(8'h00, {1'b0, i[2:0], 4'h8});
            if (i < 6) repeat (nw[i]) @(posedge clock_i);
            else begin
                i_ptc_pin_model.pulse(1'b1, 6);
                // last pin edge needs three cycles through the synchroniser
                repeat (4) @(posedge clock_i);
            end
            wr(3'h0, {1'b0, i[2:0], 4'h0});
            rd(3'h2, v);
            if (i < 6) `TB_CHK("clk src", 1'b1, v + 2 >= ex[i] && v <= ex[i] + 2)
            else `TB_CHK("ext src", 8'h03, v)
        end
        for (i = 0; i < 5; i++) begin
            start({2'b01, i[1:0], 2'b00, i[2], 1'b0}, 8'h18);
            n0 = n_cap;
            i_ptc_pin_model.pulse(i[2], 2);
            repeat (8) @(posedge clock_i);
            `TB_CHK("capture", cx[i], n_cap - n0)
        end
        wr(3'h4, 8'h05);
        wr(3'h5, 8'h00);
        for (i = 0; i < 8; i++) begin
            start({2'b00, i[2:1], i[0], i[1] ^ i[0], 1'b0, i[2] & ~i[1]}, 8'h18);
            repeat (2) @(posedge clock_i);
            #1;
            `TB_CHK("init", i[1], tpin)
            repeat (20) @(posedge clock_i);
            #1;
            hi = (i[2:1] == 0) ? i[0] : (i[2:1] == 1) ? 0 : (i[2:1] == 2) ? 1 : !i[0];
            `TB_CHK("match", hi[0] ^ i[1] ^ i[0], tpin)
        end
        wr(3'h6, 8'h0A);
        for (i = 0; i < 3; i++) begin
            start({2'b10, i[1:0], 4'h8}, 8'h18);
            hi = 0;
            repeat (100) begin
                @(posedge clock_i);
                hi += (tpin === 1'b1);
            end
            `TB_CHK("pwm", 1'b1, hi + 6 >= px[i] && hi <= px[i] + 6)
        end
        // timer mode: period 10, compare A 5, both events every period
        start(8'hC0, 8'h18);
        n0 = n_a;
        hi = n_p;
        repeat (100) @(posedge clock_i);
        #1;
        `TB_CHK("tmr a ev", 1'b1, n_a - n0 >= 9 && n_a - n0 <= 11)
        `TB_CHK("tmr p ev", 1'b1, n_p - hi >= 9 && n_p - hi <= 11)
        `TB_CHK("tmr pin", 1'b0, tpin)
        `TB_CHK("pin pair", ~tpin, tpin_n)
        finish_test();
    end
endmodule // tb_periodic_timer_control
`default_nettype wire
